// ==== logic/lcs_dev.sv ====
// Purpose: Codec end of the service boundary.
// Assumes: Lower layers give a per-channel grant and priority grant.
// Notes: Packet send path buffered by a 32-word FIFO.
`timescale 1ns/1ps
`default_nettype none
module lcs_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic [AW:0] next_wr_ptr;
	logic [AW:0] next_rd_ptr;
	logic full;
	logic empty;

	assign full = (wr_ptr[AW] != rd_ptr[AW]) &&
		(wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign empty = wr_ptr == rd_ptr;
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem[rd_ptr[AW-1:0]];

	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		if (in_valid_i && !full) begin
			next_wr_ptr = wr_ptr + 1'b1;
		end
		if (out_ready_i && !empty) begin
			next_rd_ptr = rd_ptr + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	// Storage has no reset: only entries between the pointers are read
	always_ff @(posedge clk_i) begin
		if (in_valid_i && !full) begin
			mem[wr_ptr[AW-1:0]] <= in_data_i;
		end
	end
endmodule

module lcs_dev
	import lcs_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	lcs_if.dev svc,
	output logic tx_valid_o,
	output logic [VC_W-1:0] tx_vc_o,
	output logic [DATA_W-1:0] tx_data_o,
	input wire logic [NUM_VC-1:0] tx_grant_i,
	input wire logic rx_valid_i,
	output logic rx_ready_o,
	input wire logic [VC_W-1:0] rx_vc_i,
	input wire logic [DATA_W-1:0] rx_data_i,
	output logic bc_out_valid_o,
	input wire logic bc_prio_grant_i,
	output logic [BC_CH_W-1:0] bc_out_chan_o,
	output logic [BC_SEQ_W-1:0] bc_out_seq_o,
	output logic [BC_TYPE_W-1:0] bc_out_type_o,
	output logic bc_out_late_o,
	output logic [BC_MSG_W-1:0] bc_out_msg_o,
	input wire logic bc_in_valid_i,
	input wire logic bc_in_ok_i,
	input wire logic [APP_W-1:0] bc_in_app_i,
	input wire logic [BC_CH_W-1:0] bc_in_chan_i,
	input wire logic [BC_TYPE_W-1:0] bc_in_type_i,
	input wire logic bc_in_late_i,
	input wire logic [BC_MSG_W-1:0] bc_in_msg_i,
	input wire logic [LS_W-1:0] link_state_i,
	output logic link_enable_o
);
	logic fifo_out_valid;
	logic [VC_W+DATA_W-1:0] fifo_out_data;
	logic fifo_pop;

	// Packet send: queue first, then release only on that channel's grant
	lcs_fifo #(.W(VC_W + DATA_W), .DEPTH(FIFO_DEPTH)) u_txq (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.in_valid_i(svc.pkt_tx_valid),
		.in_ready_o(svc.pkt_tx_ready),
		.in_data_i({svc.pkt_tx_vc, svc.pkt_tx_data}),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_out_data)
	);
	assign tx_valid_o = fifo_out_valid;
	assign tx_vc_o = fifo_out_data[VC_W+DATA_W-1:DATA_W];
	assign tx_data_o = fifo_out_data[DATA_W-1:0];
	assign fifo_pop = fifo_out_valid && tx_grant_i[tx_vc_o];

	// Receive holding stage, indication held until the user reads
	logic rx_full;
	logic next_rx_full;
	logic [VC_W-1:0] rx_vc;
	logic [VC_W-1:0] next_rx_vc;
	logic [DATA_W-1:0] rx_data;
	logic [DATA_W-1:0] next_rx_data;

	assign rx_ready_o = !rx_full || svc.pkt_rx_ready;
	always_comb begin
		next_rx_full = rx_full;
		next_rx_vc = rx_vc;
		next_rx_data = rx_data;
		if (rx_full && svc.pkt_rx_ready) begin
			next_rx_full = 1'b0;
		end
		if (rx_valid_i && rx_ready_o) begin
			next_rx_full = 1'b1;
			next_rx_vc = rx_vc_i;
			next_rx_data = rx_data_i;
		end
	end
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_full <= 1'b0;
			rx_vc <= '0;
			rx_data <= '0;
		end else begin
			rx_full <= next_rx_full;
			rx_vc <= next_rx_vc;
			rx_data <= next_rx_data;
		end
	end
	assign svc.pkt_rx_valid = rx_full;
	assign svc.pkt_rx_vc = rx_vc;
	assign svc.pkt_rx_data = rx_data;

	// Broadcast send: one held message, waits only for priority grant
	lcs_bc_state_t bc_state;
	lcs_bc_state_t next_bc_state;
	logic [BC_CH_W+BC_SEQ_W+BC_TYPE_W+BC_MSG_W:0] bc_hold;
	logic [BC_CH_W+BC_SEQ_W+BC_TYPE_W+BC_MSG_W:0] next_bc_hold;

	assign svc.bc_tx_ready = bc_state == LCS_BC_IDLE;
	always_comb begin
		next_bc_state = bc_state;
		next_bc_hold = bc_hold;
		case (bc_state)
			LCS_BC_IDLE: begin
				if (svc.bc_tx_valid) begin
					next_bc_state = LCS_BC_WAIT;
					next_bc_hold = {svc.bc_tx_chan, svc.bc_tx_seq,
						svc.bc_tx_type, svc.bc_tx_late, svc.bc_tx_msg};
				end
			end
			LCS_BC_WAIT: begin
				if (bc_prio_grant_i) begin
					next_bc_state = LCS_BC_IDLE;
				end
			end
			default: next_bc_state = LCS_BC_IDLE;
		endcase
	end
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bc_state <= LCS_BC_IDLE;
			bc_hold <= '0;
		end else begin
			bc_state <= next_bc_state;
			bc_hold <= next_bc_hold;
		end
	end
	assign bc_out_valid_o = bc_state == LCS_BC_WAIT;
	assign {bc_out_chan_o, bc_out_seq_o, bc_out_type_o, bc_out_late_o,
		bc_out_msg_o} = bc_hold;

	// Broadcast receive: only checked frames reach the network layer
	logic bc_ind;
	logic next_bc_ind;
	logic [APP_W+BC_CH_W+BC_TYPE_W+BC_MSG_W:0] bc_rx;
	logic [APP_W+BC_CH_W+BC_TYPE_W+BC_MSG_W:0] next_bc_rx;

	always_comb begin
		next_bc_ind = bc_in_valid_i && bc_in_ok_i;
		next_bc_rx = bc_rx;
		if (next_bc_ind) begin
			next_bc_rx = {bc_in_app_i, bc_in_chan_i, bc_in_type_i,
				bc_in_late_i, bc_in_msg_i};
		end
	end
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bc_ind <= 1'b0;
			bc_rx <= '0;
		end else begin
			bc_ind <= next_bc_ind;
			bc_rx <= next_bc_rx;
		end
	end
	assign svc.bc_rx_valid = bc_ind;
	assign {svc.bc_rx_app, svc.bc_rx_chan, svc.bc_rx_type, svc.bc_rx_late,
		svc.bc_rx_msg} = bc_rx;

	// Management parameters; fixed one-cycle read latency keeps order
	logic [MG_VAL_W-1:0] mg_param [MG_NUM];
	logic [MG_VAL_W-1:0] next_mg_param [MG_NUM];
	logic mg_resp;
	logic next_mg_resp;
	logic [MG_VAL_W-1:0] mg_resp_val;
	logic [MG_VAL_W-1:0] next_mg_resp_val;

	always_comb begin
		next_mg_param = mg_param;
		next_mg_resp = svc.mg_rd_valid;
		next_mg_resp_val = mg_resp_val;
		if (svc.mg_wr_valid) begin
			next_mg_param[svc.mg_wr_id] = svc.mg_wr_value;
		end
		if (svc.mg_rd_valid) begin
			// Read sees the value before a same-cycle write
			next_mg_resp_val = mg_param[svc.mg_rd_id];
		end
	end
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < MG_NUM; i++) begin
				mg_param[i] <= MG_RESET;
			end
			mg_resp <= 1'b0;
			mg_resp_val <= '0;
		end else begin
			mg_param <= next_mg_param;
			mg_resp <= next_mg_resp;
			mg_resp_val <= next_mg_resp_val;
		end
	end
	assign svc.mgmt_rd_resp_valid = mg_resp;
	assign svc.mgmt_rd_resp_value = mg_resp_val;
	assign link_enable_o = mg_param[MG_ID_CTRL][MG_CTRL_EN_BIT];

	// Link status change detector
	logic [LS_W-1:0] ls_last;
	logic [LS_W-1:0] next_ls_last;
	logic ls_ind;
	logic next_ls_ind;

	always_comb begin
		next_ls_last = link_state_i;
		next_ls_ind = link_state_i != ls_last;
	end
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ls_last <= LS_DOWN;
			ls_ind <= 1'b0;
		end else begin
			ls_last <= next_ls_last;
			ls_ind <= next_ls_ind;
		end
	end
	assign svc.ls_valid = ls_ind;
	assign svc.ls_status = ls_last;
endmodule
`default_nettype wire

// ==== logic/lcs_pkg.sv ====
// Purpose: Shared constants for the link codec service boundary.
// Assumes: One clock for both ends, active-low asynchronous reset.
// Notes: Status encoding and parameter map are local choices.
// Overview of operation
// - User issues packet send with channel and data
// - Codec sends packet when channel access granted
// - Codec indicates received data with channel number
// - Reading user then reads the pending data
// - Network layer requests broadcast with all fields
// - Broadcast sent at once, only priority defers
// - Only valid broadcasts reach the network layer
// - Network layer checks, forwards valid broadcasts only
// - Management write replaces the identified parameter
// - Every management read without a same-cycle write gets a value response
// - Status change raises indication with new status
package lcs_pkg;
	localparam int VC_W = 3;
	localparam int NUM_VC = 8;
	localparam int DATA_W = 32;
	localparam int FIFO_DEPTH = 32;
	localparam int BC_CH_W = 8;
	localparam int BC_SEQ_W = 8;
	localparam int BC_TYPE_W = 8;
	localparam int BC_MSG_W = 64;
	localparam int APP_W = 8;
	localparam int MG_ID_W = 4;
	localparam int MG_NUM = 16;
	localparam int MG_VAL_W = 32;
	localparam int LS_W = 2;
	localparam logic [LS_W-1:0] LS_DOWN = 2'h0;
	localparam logic [LS_W-1:0] LS_UP = 2'h1;
	localparam logic [LS_W-1:0] LS_ERROR = 2'h2;
	localparam logic [MG_VAL_W-1:0] MG_RESET = 32'h0;
	localparam logic [MG_ID_W-1:0] MG_ID_CTRL = 4'h0;
	localparam int MG_CTRL_EN_BIT = 0;
	localparam logic [BC_TYPE_W-1:0] BC_TYPE_BAD = 8'h00;
	typedef enum logic [1:0] {
		LCS_BC_IDLE = 2'b01,
		LCS_BC_WAIT = 2'b10
	} lcs_bc_state_t;
endpackage

// ==== logic/lcs_if.sv ====
// Purpose: Service boundary between codec end and user end.
// Assumes: Both ends on the same clock.
// Notes: Valid/ready where a party may stall; pulses otherwise.
`timescale 1ns/1ps
`default_nettype none
interface lcs_if;
	import lcs_pkg::*;
	logic pkt_tx_valid;
	logic pkt_tx_ready;
	logic [VC_W-1:0] pkt_tx_vc;
	logic [DATA_W-1:0] pkt_tx_data;
	logic pkt_rx_valid;
	logic pkt_rx_ready;
	logic [VC_W-1:0] pkt_rx_vc;
	logic [DATA_W-1:0] pkt_rx_data;
	logic bc_tx_valid;
	logic bc_tx_ready;
	logic [BC_CH_W-1:0] bc_tx_chan;
	logic [BC_SEQ_W-1:0] bc_tx_seq;
	logic [BC_TYPE_W-1:0] bc_tx_type;
	logic bc_tx_late;
	logic [BC_MSG_W-1:0] bc_tx_msg;
	logic bc_rx_valid;
	logic [APP_W-1:0] bc_rx_app;
	logic [BC_CH_W-1:0] bc_rx_chan;
	logic [BC_TYPE_W-1:0] bc_rx_type;
	logic bc_rx_late;
	logic [BC_MSG_W-1:0] bc_rx_msg;
	logic mg_wr_valid;
	logic [MG_ID_W-1:0] mg_wr_id;
	logic [MG_VAL_W-1:0] mg_wr_value;
	logic mg_rd_valid;
	logic [MG_ID_W-1:0] mg_rd_id;
	logic mgmt_rd_resp_valid;
	logic [MG_VAL_W-1:0] mgmt_rd_resp_value;
	logic ls_valid;
	logic [LS_W-1:0] ls_status;
	modport dev (
		input pkt_tx_valid, pkt_tx_vc, pkt_tx_data, pkt_rx_ready,
		input bc_tx_valid, bc_tx_chan, bc_tx_seq, bc_tx_type, bc_tx_late,
		input bc_tx_msg, mg_wr_valid, mg_wr_id, mg_wr_value,
		input mg_rd_valid, mg_rd_id,
		output pkt_tx_ready, pkt_rx_valid, pkt_rx_vc, pkt_rx_data,
		output bc_tx_ready, bc_rx_valid, bc_rx_app, bc_rx_chan,
		output bc_rx_type, bc_rx_late, bc_rx_msg,
		output mgmt_rd_resp_valid, mgmt_rd_resp_value, ls_valid, ls_status
	);
	modport usr (
		output pkt_tx_valid, pkt_tx_vc, pkt_tx_data, pkt_rx_ready,
		output bc_tx_valid, bc_tx_chan, bc_tx_seq, bc_tx_type, bc_tx_late,
		output bc_tx_msg, mg_wr_valid, mg_wr_id, mg_wr_value,
		output mg_rd_valid, mg_rd_id,
		input pkt_tx_ready, pkt_rx_valid, pkt_rx_vc, pkt_rx_data,
		input bc_tx_ready, bc_rx_valid, bc_rx_app, bc_rx_chan,
		input bc_rx_type, bc_rx_late, bc_rx_msg,
		input mgmt_rd_resp_valid, mgmt_rd_resp_value, ls_valid, ls_status
	);
endinterface
`default_nettype wire

// ==== logic/lcs_usr.sv ====
// Purpose: User end: packet user, network layer, management user.
// Assumes: Application requests arrive as single-cycle strobes.
// Notes: Each request is held in a register until taken.
`timescale 1ns/1ps
`default_nettype none
module lcs_usr
	import lcs_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	lcs_if.usr svc,
	input wire logic app_tx_valid_i,
	output logic app_tx_ready_o,
	input wire logic [VC_W-1:0] app_tx_vc_i,
	input wire logic [DATA_W-1:0] app_tx_data_i,
	output logic app_rx_valid_o,
	input wire logic app_rx_ready_i,
	output logic [VC_W-1:0] app_rx_vc_o,
	output logic [DATA_W-1:0] app_rx_data_o,
	input wire logic app_bc_valid_i,
	output logic app_bc_ready_o,
	input wire logic [BC_CH_W-1:0] app_bc_chan_i,
	input wire logic [BC_SEQ_W-1:0] app_bc_seq_i,
	input wire logic [BC_TYPE_W-1:0] app_bc_type_i,
	input wire logic app_bc_late_i,
	input wire logic [BC_MSG_W-1:0] app_bc_msg_i,
	input wire logic app_bc_accept_late_i,
	output logic app_bc_fwd_o,
	output logic [BC_CH_W-1:0] app_bc_fwd_chan_o,
	output logic [BC_MSG_W-1:0] app_bc_fwd_msg_o,
	input wire logic app_mg_wr_i,
	input wire logic app_mg_rd_i,
	input wire logic [MG_ID_W-1:0] app_mg_id_i,
	input wire logic [MG_VAL_W-1:0] app_mg_value_i,
	output logic app_mg_done_o,
	output logic [MG_VAL_W-1:0] app_mg_rd_value_o,
	output logic app_link_event_o,
	output logic [LS_W-1:0] app_link_status_o
);
	localparam int PKT_W = VC_W + DATA_W;
	localparam int BC_W = BC_CH_W + BC_SEQ_W + BC_TYPE_W + 1 + BC_MSG_W;

	logic tx_full, next_tx_full;
	logic [PKT_W-1:0] tx_pkt, next_tx_pkt;
	logic rx_full, next_rx_full;
	logic [PKT_W-1:0] rx_pkt, next_rx_pkt;
	logic bc_full, next_bc_full;
	logic [BC_W-1:0] bc_req, next_bc_req;
	logic fwd, next_fwd;
	logic [BC_CH_W+BC_MSG_W-1:0] fwd_data, next_fwd_data;
	logic mg_wr, next_mg_wr;
	logic mg_rd, next_mg_rd;
	logic [MG_ID_W-1:0] mg_id, next_mg_id;
	logic [MG_VAL_W-1:0] mg_val, next_mg_val;
	logic mg_done, next_mg_done;
	logic [MG_VAL_W-1:0] mg_rd_val, next_mg_rd_val;
	logic ls_ev, next_ls_ev;
	logic [LS_W-1:0] ls_st, next_ls_st;
	logic bc_ok;

	assign app_tx_ready_o = !tx_full || svc.pkt_tx_ready;
	assign app_bc_ready_o = !bc_full || svc.bc_tx_ready;
	// Auto-read whenever the local slot is free or being emptied
	assign svc.pkt_rx_ready = !rx_full || app_rx_ready_i;
	// Reserved type and unwanted late messages are dropped
	assign bc_ok = svc.bc_rx_type != BC_TYPE_BAD &&
		(!svc.bc_rx_late || app_bc_accept_late_i);

	always_comb begin
		next_tx_full = tx_full;
		next_tx_pkt = tx_pkt;
		if (tx_full && svc.pkt_tx_ready) begin
			next_tx_full = 1'b0;
		end
		if (app_tx_valid_i && app_tx_ready_o) begin
			next_tx_full = 1'b1;
			next_tx_pkt = {app_tx_vc_i, app_tx_data_i};
		end
		next_rx_full = rx_full;
		next_rx_pkt = rx_pkt;
		if (rx_full && app_rx_ready_i) begin
			next_rx_full = 1'b0;
		end
		if (svc.pkt_rx_valid && svc.pkt_rx_ready) begin
			next_rx_full = 1'b1;
			next_rx_pkt = {svc.pkt_rx_vc, svc.pkt_rx_data};
		end
		next_bc_full = bc_full;
		next_bc_req = bc_req;
		if (bc_full && svc.bc_tx_ready) begin
			next_bc_full = 1'b0;
		end
		if (app_bc_valid_i && app_bc_ready_o) begin
			next_bc_full = 1'b1;
			next_bc_req = {app_bc_chan_i, app_bc_seq_i, app_bc_type_i,
				app_bc_late_i, app_bc_msg_i};
		end
		next_fwd = svc.bc_rx_valid && bc_ok;
		next_fwd_data = next_fwd ? {svc.bc_rx_chan, svc.bc_rx_msg} : fwd_data;
		next_mg_wr = app_mg_wr_i;
		next_mg_rd = app_mg_rd_i && !app_mg_wr_i;
		next_mg_id = app_mg_id_i;
		next_mg_val = app_mg_value_i;
		next_mg_done = svc.mgmt_rd_resp_valid;
		next_mg_rd_val = svc.mgmt_rd_resp_valid ? svc.mgmt_rd_resp_value :
			mg_rd_val;
		next_ls_ev = svc.ls_valid;
		next_ls_st = svc.ls_valid ? svc.ls_status : ls_st;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_full <= 1'b0;
			tx_pkt <= '0;
			rx_full <= 1'b0;
			rx_pkt <= '0;
			bc_full <= 1'b0;
			bc_req <= '0;
			fwd <= 1'b0;
			fwd_data <= '0;
			mg_wr <= 1'b0;
			mg_rd <= 1'b0;
			mg_id <= '0;
			mg_val <= '0;
			mg_done <= 1'b0;
			mg_rd_val <= '0;
			ls_ev <= 1'b0;
			ls_st <= LS_DOWN;
		end else begin
			tx_full <= next_tx_full;
			tx_pkt <= next_tx_pkt;
			rx_full <= next_rx_full;
			rx_pkt <= next_rx_pkt;
			bc_full <= next_bc_full;
			bc_req <= next_bc_req;
			fwd <= next_fwd;
			fwd_data <= next_fwd_data;
			mg_wr <= next_mg_wr;
			mg_rd <= next_mg_rd;
			mg_id <= next_mg_id;
			mg_val <= next_mg_val;
			mg_done <= next_mg_done;
			mg_rd_val <= next_mg_rd_val;
			ls_ev <= next_ls_ev;
			ls_st <= next_ls_st;
		end
	end

	assign svc.pkt_tx_valid = tx_full;
	assign {svc.pkt_tx_vc, svc.pkt_tx_data} = tx_pkt;
	assign app_rx_valid_o = rx_full;
	assign {app_rx_vc_o, app_rx_data_o} = rx_pkt;
	assign svc.bc_tx_valid = bc_full;
	assign {svc.bc_tx_chan, svc.bc_tx_seq, svc.bc_tx_type, svc.bc_tx_late,
		svc.bc_tx_msg} = bc_req;
	assign app_bc_fwd_o = fwd;
	assign {app_bc_fwd_chan_o, app_bc_fwd_msg_o} = fwd_data;
	assign svc.mg_wr_valid = mg_wr;
	assign svc.mg_rd_valid = mg_rd;
	assign svc.mg_wr_id = mg_id;
	assign svc.mg_rd_id = mg_id;
	assign svc.mg_wr_value = mg_val;
	assign app_mg_done_o = mg_done;
	assign app_mg_rd_value_o = mg_rd_val;
	assign app_link_event_o = ls_ev;
	assign app_link_status_o = ls_st;
endmodule
`default_nettype wire

// ==== verif/lcs_asserts.sv ====
// Purpose: Concurrent checks on the service boundary between both ends.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Sees boundary signals only; plain ports are judged by the bench.
`timescale 1ns/1ps
`default_nettype none
module lcs_asserts
	import lcs_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic pkt_tx_valid,
	input wire logic pkt_tx_ready,
	input wire logic [DATA_W-1:0] pkt_tx_data,
	input wire logic pkt_rx_valid,
	input wire logic pkt_rx_ready,
	input wire logic [DATA_W-1:0] pkt_rx_data,
	input wire logic bc_tx_valid,
	input wire logic bc_tx_ready,
	input wire logic [BC_MSG_W-1:0] bc_tx_msg,
	input wire logic bc_rx_valid,
	input wire logic mg_wr_valid,
	input wire logic [MG_ID_W-1:0] mg_wr_id,
	input wire logic [MG_VAL_W-1:0] mg_wr_value,
	input wire logic mg_rd_valid,
	input wire logic [MG_ID_W-1:0] mg_rd_id,
	input wire logic mgmt_rd_resp_valid,
	input wire logic [MG_VAL_W-1:0] mgmt_rd_resp_value,
	input wire logic ls_valid,
	input wire logic [LS_W-1:0] ls_status
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	a_pkt_tx_hold: assert property (pkt_tx_valid && !pkt_tx_ready
		|=> pkt_tx_valid && $stable(pkt_tx_data)) else $error("send word dropped");
	a_pkt_rx_hold: assert property (pkt_rx_valid && !pkt_rx_ready
		|=> pkt_rx_valid && $stable(pkt_rx_data)) else $error("rx word lost");
	a_bc_tx_hold: assert property (bc_tx_valid && !bc_tx_ready
		|=> bc_tx_valid && $stable(bc_tx_msg)) else $error("broadcast dropped");
	a_bc_tx_busy: assert property (bc_tx_valid && bc_tx_ready
		|=> !bc_tx_ready) else $error("broadcast taken twice");
	a_mg_rd_answer: assert property (mg_rd_valid
		|=> mgmt_rd_resp_valid) else $error("read not answered");
	a_mg_resp_cause: assert property (mgmt_rd_resp_valid
		|-> $past(mg_rd_valid)) else $error("response without read");
	// Same-cycle write and read is refused as write only, so exclude it
	a_mg_wr_rd: assert property ((mg_wr_valid ##1 (mg_rd_valid &&
		!mg_wr_valid && mg_rd_id == $past(mg_wr_id)))
		|=> mgmt_rd_resp_value == $past(mg_wr_value, 2))
		else $error("written value not read back");
	a_ls_change: assert property ($changed(ls_status)
		|-> ls_valid) else $error("status change not indicated");
	a_ls_pulse: assert property (ls_valid
		|-> $changed(ls_status)) else $error("indication without change");
	c_tx_full: cover property (pkt_tx_valid && !pkt_tx_ready);
	c_bc_rx: cover property (bc_rx_valid);
	c_rd_burst: cover property (mgmt_rd_resp_valid ##1 mgmt_rd_resp_valid);
	c_ls: cover property (ls_valid);
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench joining codec end and user end.
// Assumes: 200 MHz clock; inputs driven by non-blocking at rising edge.
// Notes: Status encoding and parameter map follow the package.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import lcs_pkg::*;
;
	int miscompares = 0, n_checks = 0, n, m;
	logic clk_i = 1'b0, nrst_i = 1'b0, rx_valid_i = 1'b0;
	logic bc_prio_grant_i = 1'b0, bc_in_valid_i = 1'b0, bc_in_ok_i = 1'b0;
	logic bc_in_late_i = 1'b0, app_tx_valid_i = 1'b0, app_rx_ready_i = 1'b0;
	logic app_bc_valid_i = 1'b0, app_bc_late_i = 1'b0, app_mg_wr_i = 1'b0;
	logic app_bc_accept_late_i = 1'b0, app_mg_rd_i = 1'b0;
	logic [NUM_VC-1:0] tx_grant_i = 8'h00;
	logic [VC_W-1:0] rx_vc_i = 3'h0, app_tx_vc_i = 3'h0, tx_vc_o, app_rx_vc_o;
	logic [DATA_W-1:0] rx_data_i = 32'h0, app_tx_data_i = 32'h0;
	logic [DATA_W-1:0] tx_data_o, app_rx_data_o;
	logic [7:0] bc_in_app_i = 8'h00, bc_in_chan_i = 8'h00, bc_in_type_i = 8'h00;
	logic [7:0] app_bc_chan_i = 8'h00, app_bc_seq_i = 8'h00;
	logic [7:0] app_bc_type_i = 8'h00, bc_out_chan_o, bc_out_seq_o;
	logic [7:0] bc_out_type_o, app_bc_fwd_chan_o;
	logic [BC_MSG_W-1:0] bc_in_msg_i = 64'h0, app_bc_msg_i = 64'h0;
	logic [BC_MSG_W-1:0] bc_out_msg_o, app_bc_fwd_msg_o;
	logic [MG_ID_W-1:0] app_mg_id_i = 4'h0;
	logic [MG_VAL_W-1:0] app_mg_value_i = 32'h0, app_mg_rd_value_o;
	logic [LS_W-1:0] link_state_i = 2'h0, app_link_status_o;
	logic tx_valid_o, rx_ready_o, bc_out_valid_o, bc_out_late_o, link_enable_o;
	logic app_tx_ready_o, app_rx_valid_o, app_bc_ready_o, app_bc_fwd_o;
	logic app_mg_done_o, app_link_event_o;
	logic [63:0] got [0:7];

	lcs_if svc_if ();
	lcs_dev u_lcs_dev (.clk_i, .nrst_i, .svc(svc_if.dev), .tx_valid_o, .tx_vc_o,
		.tx_data_o, .tx_grant_i, .rx_valid_i, .rx_ready_o, .rx_vc_i, .rx_data_i,
		.bc_out_valid_o, .bc_prio_grant_i, .bc_out_chan_o, .bc_out_seq_o,
		.bc_out_type_o, .bc_out_late_o, .bc_out_msg_o, .bc_in_valid_i,
		.bc_in_ok_i, .bc_in_app_i, .bc_in_chan_i, .bc_in_type_i, .bc_in_late_i,
		.bc_in_msg_i, .link_state_i, .link_enable_o);
	lcs_usr u_lcs_usr (.clk_i, .nrst_i, .svc(svc_if.usr), .app_tx_valid_i,
		.app_tx_ready_o, .app_tx_vc_i, .app_tx_data_i, .app_rx_valid_o,
		.app_rx_ready_i, .app_rx_vc_o, .app_rx_data_o, .app_bc_valid_i,
		.app_bc_ready_o, .app_bc_chan_i, .app_bc_seq_i, .app_bc_type_i,
		.app_bc_late_i, .app_bc_msg_i, .app_bc_accept_late_i, .app_bc_fwd_o,
		.app_bc_fwd_chan_o, .app_bc_fwd_msg_o, .app_mg_wr_i, .app_mg_rd_i,
		.app_mg_id_i, .app_mg_value_i, .app_mg_done_o, .app_mg_rd_value_o,
		.app_link_event_o, .app_link_status_o);
	lcs_asserts u_lcs_asserts (.clk_i, .nrst_i,
		.pkt_tx_valid(svc_if.pkt_tx_valid), .pkt_tx_ready(svc_if.pkt_tx_ready),
		.pkt_tx_data(svc_if.pkt_tx_data), .pkt_rx_valid(svc_if.pkt_rx_valid),
		.pkt_rx_ready(svc_if.pkt_rx_ready), .pkt_rx_data(svc_if.pkt_rx_data),
		.bc_tx_valid(svc_if.bc_tx_valid), .bc_tx_ready(svc_if.bc_tx_ready),
		.bc_tx_msg(svc_if.bc_tx_msg), .bc_rx_valid(svc_if.bc_rx_valid),
		.mg_wr_valid(svc_if.mg_wr_valid), .mg_wr_id(svc_if.mg_wr_id),
		.mg_wr_value(svc_if.mg_wr_value), .mg_rd_valid(svc_if.mg_rd_valid),
		.mg_rd_id(svc_if.mg_rd_id), .ls_valid(svc_if.ls_valid),
		.mgmt_rd_resp_valid(svc_if.mgmt_rd_resp_valid),
		.mgmt_rd_resp_value(svc_if.mgmt_rd_resp_value),
		.ls_status(svc_if.ls_status));

	always #2.5 clk_i = ~clk_i;

	task automatic chk(input logic [63:0] gv, input logic [63:0] ev);
		n_checks++;
		if (gv !== ev) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, gv, ev);
		end
	endtask

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// A wait that used up its bound ends the run at once
	task automatic bound(input int i, input int lim);
		if (i >= lim) begin
			chk(i, lim - 1);
			close_out();
		end
	endtask

	task automatic t_pkt_tx();
		int k;
		n = 0;
		@(posedge clk_i);
		app_tx_valid_i <= 1'b1;
		app_tx_data_i <= 32'hA000_0000;
		app_tx_vc_i <= 3'h0;
		for (k = 0; k < 45; k++) begin
			@(posedge clk_i);
			if (app_tx_ready_o === 1'b1)
				n++;
			app_tx_data_i <= 32'hA000_0000 + n;
			app_tx_vc_i <= n[2:0];
		end
		app_tx_valid_i <= 1'b0;
		chk(n, FIFO_DEPTH + 1);
		// Grant only the head's channel, so a wrong channel stalls the drain
		for (k = 0; k <= FIFO_DEPTH; k++) begin
			@(posedge clk_i);
			tx_grant_i <= 8'h01 << k[2:0];
			#1;
			chk(tx_valid_o, 1'b1);
			chk(tx_data_o, 32'hA000_0000 + k);
			chk(tx_vc_o, k[2:0]);
		end
		@(posedge clk_i);
		tx_grant_i <= 8'h00;
		#1;
		chk(tx_valid_o, 1'b0);
		$display("Test pkt_tx done");
	endtask

	task automatic t_pkt_rx();
		int k;
		n = 0;
		m = 0;
		@(posedge clk_i);
		rx_valid_i <= 1'b1;
		rx_vc_i <= 3'h5;
		rx_data_i <= 32'hB000_0000;
		for (k = 0; k < 6; k++) begin
			@(posedge clk_i);
			if (rx_ready_o === 1'b1)
				n++;
			rx_data_i <= 32'hB000_0000 + n;
		end
		rx_valid_i <= 1'b0;
		#1;
		chk(n, 2);
		chk(app_rx_valid_o, 1'b1);
		chk(app_rx_vc_o, 3'h5);
		@(posedge clk_i);
		app_rx_ready_i <= 1'b1;
		for (k = 0; k < 8; k++) begin
			@(posedge clk_i);
			if (app_rx_valid_o === 1'b1 && m < 8) begin
				got[m] = app_rx_data_o;
				m++;
			end
		end
		app_rx_ready_i <= 1'b0;
		chk(m, 2);
		chk(got[0], 32'hB000_0000);
		chk(got[1], 32'hB000_0001);
		$display("Test pkt_rx done");
	endtask

	task automatic t_bc_tx();
		int k;
		@(posedge clk_i);
		app_bc_valid_i <= 1'b1;
		app_bc_chan_i <= 8'h3C;
		app_bc_seq_i <= 8'h5A;
		app_bc_type_i <= 8'h07;
		app_bc_late_i <= 1'b1;
		app_bc_msg_i <= 64'h0123_4567_89AB_CDEF;
		for (k = 0; k < 8; k++) begin
			@(posedge clk_i);
			if (app_bc_ready_o === 1'b1)
				break;
		end
		bound(k, 8);
		// Second message queues while the first waits
		app_bc_chan_i <= 8'h3D;
		app_bc_msg_i <= 64'hFEDC_BA98_7654_3210;
		@(posedge clk_i);
		chk(app_bc_ready_o, 1'b1);
		app_bc_valid_i <= 1'b0;
		for (k = 0; k < 3; k++) begin
			@(posedge clk_i);
			#1;
			if (bc_out_valid_o === 1'b1)
				break;
		end
		bound(k, 3);
		// Priority withheld: the message must stand, not vanish
		repeat (3) begin
			@(posedge clk_i);
			#1;
			chk(bc_out_valid_o, 1'b1);
		end
		chk(bc_out_chan_o, 8'h3C);
		chk(bc_out_seq_o, 8'h5A);
		chk(bc_out_type_o, 8'h07);
		chk(bc_out_late_o, 1'b1);
		chk(bc_out_msg_o, 64'h0123_4567_89AB_CDEF);
		@(posedge clk_i);
		bc_prio_grant_i <= 1'b1;
		@(posedge clk_i);
		bc_prio_grant_i <= 1'b0;
		#1;
		chk(bc_out_valid_o, 1'b0);
		@(posedge clk_i);
		bc_prio_grant_i <= 1'b1;
		#1;
		chk(bc_out_valid_o, 1'b1);
		chk(bc_out_chan_o, 8'h3D);
		chk(bc_out_msg_o, 64'hFEDC_BA98_7654_3210);
		@(posedge clk_i);
		bc_prio_grant_i <= 1'b0;
		#1;
		chk(bc_out_valid_o, 1'b0);
		$display("Test bc_tx done");
	endtask

	task automatic t_bc_rx();
		int i;
		int k;
		for (i = 0; i < 16; i++) begin
			@(posedge clk_i);
			bc_in_valid_i <= 1'b1;
			bc_in_ok_i <= i[3];
			bc_in_type_i <= i[2] ? BC_TYPE_BAD : 8'h05;
			bc_in_late_i <= i[1];
			app_bc_accept_late_i <= i[0];
			bc_in_app_i <= 8'h40 + i[7:0];
			bc_in_chan_i <= 8'h20 + i[7:0];
			bc_in_msg_i <= {8{i[7:0]}};
			@(posedge clk_i);
			bc_in_valid_i <= 1'b0;
			n = 0;
			m = 0;
			for (k = 0; k < 4; k++) begin
				#1;
				if (svc_if.bc_rx_valid === 1'b1) begin
					n++;
					chk(svc_if.bc_rx_app, 8'h40 + i[7:0]);
				end
				if (app_bc_fwd_o === 1'b1) begin
					m++;
					chk(app_bc_fwd_chan_o, 8'h20 + i[7:0]);
					chk(app_bc_fwd_msg_o, {8{i[7:0]}});
				end
				@(posedge clk_i);
			end
			chk(n, i[3]);
			chk(m, i[3] && !i[2] && (!i[1] || i[0]));
		end
		$display("Test bc_rx done");
	endtask

	task automatic mg_req(input logic wr, input logic [MG_ID_W-1:0] id,
		input logic [MG_VAL_W-1:0] v);
		@(posedge clk_i);
		app_mg_wr_i <= wr;
		app_mg_rd_i <= !wr;
		app_mg_id_i <= id;
		app_mg_value_i <= v;
	endtask

	task automatic t_mg();
		int k;
		n = 0;
		m = 0;
		fork
			begin
				mg_req(1'b1, 4'h3, 32'h1234_5678);
				mg_req(1'b1, MG_ID_CTRL, 32'h0000_0001);
				mg_req(1'b0, MG_ID_CTRL, 32'h0);
				mg_req(1'b0, 4'h3, 32'h0);
				mg_req(1'b0, 4'hF, 32'h0);
				@(posedge clk_i);
				app_mg_rd_i <= 1'b0;
			end
			for (k = 0; k < 14; k++) begin
				@(posedge clk_i);
				#1;
				if (svc_if.mgmt_rd_resp_valid === 1'b1)
					n++;
				if (app_mg_done_o === 1'b1 && m < 8) begin
					got[m] = app_mg_rd_value_o;
					m++;
				end
			end
		join
		chk(n, 3);
		chk(got[m - 3], 32'h0000_0001);
		chk(got[m - 2], 32'h1234_5678);
		chk(got[m - 1], MG_RESET);
		chk(link_enable_o, 1'b1);
		$display("Test mg done");
	endtask

	task automatic t_ls();
		int j;
		int k;
		logic [LS_W-1:0] s [0:2] = '{LS_UP, LS_ERROR, LS_DOWN};
		for (j = 0; j < 3; j++) begin
			@(posedge clk_i);
			link_state_i <= s[j];
			for (k = 0; k < 6; k++) begin
				@(posedge clk_i);
				#1;
				if (app_link_event_o === 1'b1)
					break;
			end
			bound(k, 6);
			chk(app_link_status_o, s[j]);
			chk(svc_if.ls_status, s[j]);
			n = 0;
			repeat (4) begin
				@(posedge clk_i);
				#1;
				if (app_link_event_o === 1'b1)
					n++;
			end
			chk(n, 0);
		end
		$display("Test ls done");
	endtask

	initial begin
		repeat (20) @(posedge clk_i);
		#1;
		chk(tx_valid_o, 1'b0);
		chk(app_tx_ready_o, 1'b1);
		chk(link_enable_o, 1'b0);
		@(posedge clk_i);
		nrst_i <= 1'b1;
		t_pkt_tx();
		t_pkt_rx();
		t_bc_tx();
		t_bc_rx();
		t_mg();
		t_ls();
		close_out();
	end
endmodule
`default_nettype wire
